// ===== logic/jbsisp_port.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Test access port with boundary scan and programming
module jbsisp_port #(
  parameter int NumIo    = 24,  // User I/O pins
  parameter int ChainLen = 96   // Boundary cells, 96..624
) (
  input  wire logic             sys_clk,    // System clock
  input  wire logic             rst,        // Async reset, high
  input  wire logic             testPortEn, // Port in use by design
  input  wire logic             tckPin,     // Test clock pin
  input  wire logic             tmsPin,     // Mode select pin
  input  wire logic             tdiPin,     // Data in pin
  output logic                  tdoOut,     // Data out value
  output logic                  tdoOe,      // Data out enable
  input  wire logic [3:0]       portUserOut,// Core drive for port pins
  input  wire logic [3:0]       portUserOe, // Core enable for port pins
  output logic      [3:0]       portPinOut, // Port pins as user I/O
  output logic      [3:0]       portPinOe,  // Their enables
  input  wire logic [NumIo-1:0] coreOut,    // Core output data
  input  wire logic [NumIo-1:0] coreOe,     // Core output enables
  input  wire logic [NumIo-1:0] pinIn,      // Pin levels
  output logic      [NumIo-1:0] coreIn,     // Pin levels to core
  output logic      [NumIo-1:0] pinOut,     // Pin drive value
  output logic      [NumIo-1:0] pinOe,      // Pin drive enable
  output logic                  pullUpEn,   // Weak pull-ups on
  output logic                  progBusy,   // Programming active
  output logic                  doneFlag    // Completion flag state
);
  // ==========================================================
  // Declarations
  localparam int CellsUsed = 3 * NumIo;          // In, out, oe per pin
  logic [2:0]       tckS;                        // Synced tck, tms, tdi
  logic             tck, tms, tdi;               // Synchronised pins
  logic             tckOld_q, tckOld_d;          // Edge detect
  logic             tckRise, tckFall;            // Edge strobes
  jbsisp_pkg::jbs_state_t st_q, st_d;            // Controller state
  logic [jbsisp_pkg::IrLen-1:0] irSh_q, irSh_d;  // IR shift stage
  logic [jbsisp_pkg::IrLen-1:0] ir_q, ir_d;      // IR update stage
  logic [jbsisp_pkg::IdLen-1:0] idSh_q, idSh_d;  // Id/user/config shift
  logic             byp_q, byp_d;                // Bypass stage
  logic [ChainLen-1:0] bsSh_q, bsSh_d;           // Boundary shift
  logic [ChainLen-1:0] bsUp_q, bsUp_d;           // Boundary update
  logic [jbsisp_pkg::IdLen-1:0] user_q, user_d;  // Stored user code
  logic [jbsisp_pkg::CfgW-1:0]  cfg_q, cfg_d;    // Stored config word
  logic             done_q, done_d;              // Completion flag
  logic             progMode_q, progMode_d;      // Programming mode
  logic             tdo_q, tdo_d;                // Falling-edge data
  logic             tdoOe_q, tdoOe_d;            // Falling-edge enable
  logic [ChainLen-1:0] capVec;                   // Capture pattern
  logic             serOut;                      // Selected register LSB
  logic [jbsisp_pkg::IdLen-1:0] idWord;          // Identification word

  // Port pins pass through synchronisers
  jbsisp_sync #(.W(3)) uSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({tckPin, tmsPin, tdiPin}),
    .dout    (tckS)
  );
  assign tck = tckS[2];
  assign tms = tckS[1];
  assign tdi = tckS[0];
  // All three pins share one synchroniser so their
  // relative timing is kept cycle for cycle
  assign tckRise = tck & ~tckOld_q;
  assign tckFall = ~tck & tckOld_q;

  // Identification word, LSB forced to one
  assign idWord = {jbsisp_pkg::IdVersion, jbsisp_pkg::IdPart,
                   jbsisp_pkg::IdMaker, jbsisp_pkg::IdLsb};

  // ==========================================================
  // Instruction decode helper, used more than once
  function automatic logic isBsMode(input logic [jbsisp_pkg::IrLen-1:0] ins);
    isBsMode = (ins == jbsisp_pkg::InsExtest) || (ins == jbsisp_pkg::InsSample);
  endfunction
  function automatic logic isKnown(input logic [jbsisp_pkg::IrLen-1:0] ins);
    isKnown = isBsMode(ins) || ins == jbsisp_pkg::InsIdcode ||
              ins == jbsisp_pkg::InsUsercode || ins == jbsisp_pkg::InsEnable ||
              ins == jbsisp_pkg::InsErase || ins == jbsisp_pkg::InsProgram ||
              ins == jbsisp_pkg::InsVerify || ins == jbsisp_pkg::InsSetDone ||
              ins == jbsisp_pkg::InsDisable;
  endfunction

  // ==========================================================
  // Boundary capture: per pin input, output, enable cells
  genvar g;
  generate
    for (g = 0; g < ChainLen; g++) begin : gCap
      if (g < CellsUsed) begin : gUsed
        if (g % 3 == 0) begin : gIn
          assign capVec[g] = pinIn[g/3];
        end else if (g % 3 == 1) begin : gOut
          assign capVec[g] = coreOut[g/3];
        end else begin : gOe
          assign capVec[g] = coreOe[g/3];
        end
      end else begin : gSpare
        assign capVec[g] = 1'b0;
      end
    end
    // Pin drivers: extest uses update cells, else core
    for (g = 0; g < NumIo; g++) begin : gPin
      logic ext;
      assign ext = (ir_q == jbsisp_pkg::InsExtest);
      assign pinOut[g] = ext ? bsUp_q[3*g+1] : coreOut[g];
      // Pins released only when not programming and flag set
      assign pinOe[g]  = (progMode_q || !done_q) ? 1'b0 :
                         (ext ? bsUp_q[3*g+2] : coreOe[g]);
      assign coreIn[g] = pinIn[g];
    end
  endgenerate
  assign pullUpEn = progMode_q;
  assign progBusy = progMode_q;
  assign doneFlag = done_q;

  // Port pins: user I/O when the test port is unused
  assign portPinOut = portUserOut;
  assign portPinOe  = testPortEn ? 4'h0 : portUserOe;
  assign tdoOut = tdo_q;
  assign tdoOe  = tdoOe_q & testPortEn;

  // Selected register output bit
  always_comb begin
    serOut = byp_q;
    if (st_q == jbsisp_pkg::JbsShIr) begin
      serOut = irSh_q[0];
    end else if (isBsMode(ir_q)) begin
      serOut = bsSh_q[0];
    end else if (isKnown(ir_q)) begin
      serOut = idSh_q[0];
    end
  end

  // ==========================================================
  // Controller and register next-state logic
  always_comb begin
    st_d = st_q; irSh_d = irSh_q; ir_d = ir_q; idSh_d = idSh_q;
    byp_d = byp_q; bsSh_d = bsSh_q; bsUp_d = bsUp_q; user_d = user_q;
    cfg_d = cfg_q; done_d = done_q; progMode_d = progMode_q;
    tdo_d = tdo_q; tdoOe_d = tdoOe_q; tckOld_d = tck;
    if (tckRise && testPortEn) begin
      // Sixteen-state walk on TMS
      case (st_q)
        jbsisp_pkg::JbsTlr:   st_d = tms ? jbsisp_pkg::JbsTlr   : jbsisp_pkg::JbsRti;
        jbsisp_pkg::JbsRti:   st_d = tms ? jbsisp_pkg::JbsSelDr : jbsisp_pkg::JbsRti;
        jbsisp_pkg::JbsSelDr: st_d = tms ? jbsisp_pkg::JbsSelIr : jbsisp_pkg::JbsCapDr;
        jbsisp_pkg::JbsCapDr: st_d = tms ? jbsisp_pkg::JbsEx1Dr : jbsisp_pkg::JbsShDr;
        jbsisp_pkg::JbsShDr:  st_d = tms ? jbsisp_pkg::JbsEx1Dr : jbsisp_pkg::JbsShDr;
        jbsisp_pkg::JbsEx1Dr: st_d = tms ? jbsisp_pkg::JbsUpdDr : jbsisp_pkg::JbsPauDr;
        jbsisp_pkg::JbsPauDr: st_d = tms ? jbsisp_pkg::JbsEx2Dr : jbsisp_pkg::JbsPauDr;
        jbsisp_pkg::JbsEx2Dr: st_d = tms ? jbsisp_pkg::JbsUpdDr : jbsisp_pkg::JbsShDr;
        jbsisp_pkg::JbsUpdDr: st_d = tms ? jbsisp_pkg::JbsSelDr : jbsisp_pkg::JbsRti;
        jbsisp_pkg::JbsSelIr: st_d = tms ? jbsisp_pkg::JbsTlr   : jbsisp_pkg::JbsCapIr;
        jbsisp_pkg::JbsCapIr: st_d = tms ? jbsisp_pkg::JbsEx1Ir : jbsisp_pkg::JbsShIr;
        jbsisp_pkg::JbsShIr:  st_d = tms ? jbsisp_pkg::JbsEx1Ir : jbsisp_pkg::JbsShIr;
        jbsisp_pkg::JbsEx1Ir: st_d = tms ? jbsisp_pkg::JbsUpdIr : jbsisp_pkg::JbsPauIr;
        jbsisp_pkg::JbsPauIr: st_d = tms ? jbsisp_pkg::JbsEx2Ir : jbsisp_pkg::JbsPauIr;
        jbsisp_pkg::JbsEx2Ir: st_d = tms ? jbsisp_pkg::JbsUpdIr : jbsisp_pkg::JbsShIr;
        jbsisp_pkg::JbsUpdIr: st_d = tms ? jbsisp_pkg::JbsSelDr : jbsisp_pkg::JbsRti;
        default:              st_d = jbsisp_pkg::JbsTlr;
      endcase
      // Register actions in the state being left
      case (st_q)
        jbsisp_pkg::JbsTlr: begin
          ir_d = jbsisp_pkg::InsIdcode;
          progMode_d = 1'b0;
        end
        jbsisp_pkg::JbsCapIr: irSh_d = jbsisp_pkg::IrCaptureVal;
        jbsisp_pkg::JbsShIr: begin
          irSh_d = {tdi, irSh_q[jbsisp_pkg::IrLen-1:1]};
        end
        jbsisp_pkg::JbsUpdIr: ir_d = irSh_q;
        jbsisp_pkg::JbsCapDr: begin
          byp_d = 1'b0;
          if (isBsMode(ir_q)) begin
            bsSh_d = capVec;
          end else if (ir_q == jbsisp_pkg::InsIdcode) begin
            idSh_d = idWord;
          end else if (ir_q == jbsisp_pkg::InsUsercode) begin
            idSh_d = user_q;
          end else if (ir_q == jbsisp_pkg::InsVerify) begin
            idSh_d = {{(jbsisp_pkg::IdLen-jbsisp_pkg::CfgW){1'b0}}, cfg_q};
          end else begin
            idSh_d = '0;
          end
        end
        jbsisp_pkg::JbsShDr: begin
          byp_d = tdi;
          if (isBsMode(ir_q)) begin
            bsSh_d = {tdi, bsSh_q[ChainLen-1:1]};
          end else begin
            idSh_d = {tdi, idSh_q[jbsisp_pkg::IdLen-1:1]};
          end
        end
        jbsisp_pkg::JbsUpdDr: begin
          if (isBsMode(ir_q)) begin
            bsUp_d = bsSh_q;
          end
          // Programming actions only in programming mode
          if (progMode_q) begin
            case (ir_q)
              jbsisp_pkg::InsErase: begin
                cfg_d = jbsisp_pkg::CfgErased;
                user_d = jbsisp_pkg::UserCodeDefault;
                done_d = 1'b0;
              end
              jbsisp_pkg::InsProgram: begin
                cfg_d = cfg_q & idSh_q[jbsisp_pkg::CfgW-1:0];
                user_d = idSh_q;
              end
              // Flag: accepted at any step while in programming mode
              jbsisp_pkg::InsSetDone: done_d = 1'b1;
              default: ;
            endcase
          end
        end
        jbsisp_pkg::JbsRti: begin
          if (ir_q == jbsisp_pkg::InsEnable) begin
            progMode_d = 1'b1;
          end else if (ir_q == jbsisp_pkg::InsDisable) begin
            progMode_d = 1'b0;
          end
        end
        default: ;
      endcase
      if (st_q == jbsisp_pkg::JbsUpdIr && !isKnown(irSh_q)) begin
        ir_d = jbsisp_pkg::InsBypass;
      end
    end
    if (tckFall) begin
      // Data out moves on the falling edge
      tdo_d   = serOut;
      tdoOe_d = (st_q == jbsisp_pkg::JbsShDr) || (st_q == jbsisp_pkg::JbsShIr);
    end
    if (!testPortEn) begin
      st_d = jbsisp_pkg::JbsTlr;
      tdoOe_d = 1'b0;
    end
  end

  // ==========================================================
  // All state registered here
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= jbsisp_pkg::JbsTlr;
      irSh_q <= '0;
      ir_q <= jbsisp_pkg::InsIdcode;
      idSh_q <= '0;
      byp_q <= 1'b0;
      bsSh_q <= '0;
      bsUp_q <= '0;
      user_q <= jbsisp_pkg::UserCodeDefault;
      cfg_q <= jbsisp_pkg::CfgErased;
      done_q <= 1'b0;
      progMode_q <= 1'b0;
      tdo_q <= 1'b0;
      tdoOe_q <= 1'b0;
      tckOld_q <= 1'b0;
    end else begin
      st_q <= st_d;
      irSh_q <= irSh_d;
      ir_q <= ir_d;
      idSh_q <= idSh_d;
      byp_q <= byp_d;
      bsSh_q <= bsSh_d;
      bsUp_q <= bsUp_d;
      user_q <= user_d;
      cfg_q <= cfg_d;
      done_q <= done_d;
      progMode_q <= progMode_d;
      tdo_q <= tdo_d;
      tdoOe_q <= tdoOe_d;
      tckOld_q <= tckOld_d;
    end
  end
endmodule // jbsisp_port
`default_nettype wire

// ===== logic/jbsisp_pkg.sv
package jbsisp_pkg;
  // ==========================================================
  // Sizes
  localparam int IrLen     = 10;
  localparam int IdLen     = 32;
  localparam int VerW      = 4;
  localparam int PartW     = 16;
  localparam int MfrW      = 11;
  localparam int ChainMin  = 96;
  localparam int ChainMax  = 624;
  // ==========================================================
  // Identification fields (values arbitrary, neutral)
  localparam logic [VerW-1:0]  IdVersion = 4'hA;
  localparam logic [PartW-1:0] IdPart    = 16'h1234;
  localparam logic [MfrW-1:0]  IdMaker   = 11'h155;
  localparam logic             IdLsb     = 1'b1;
  localparam logic [IdLen-1:0] UserCodeDefault = 32'hFFFFFFFF;
  // ==========================================================
  // Instruction codes (10 bits)
  localparam logic [IrLen-1:0] InsExtest   = 10'h000;
  localparam logic [IrLen-1:0] InsSample   = 10'h005;
  localparam logic [IrLen-1:0] InsIdcode   = 10'h059;
  localparam logic [IrLen-1:0] InsUsercode = 10'h007;
  localparam logic [IrLen-1:0] InsEnable   = 10'h2CC;
  localparam logic [IrLen-1:0] InsErase    = 10'h2F2;
  localparam logic [IrLen-1:0] InsProgram  = 10'h2F4;
  localparam logic [IrLen-1:0] InsVerify   = 10'h2F5;
  localparam logic [IrLen-1:0] InsSetDone  = 10'h2F9;
  localparam logic [IrLen-1:0] InsDisable  = 10'h201;
  localparam logic [IrLen-1:0] InsBypass   = 10'h3FF;
  localparam logic [IrLen-1:0] IrCaptureVal = 10'h001;
  localparam int CfgW = 16;  // Config word width
  localparam logic [CfgW-1:0] CfgErased = 16'hFFFF;
  // ==========================================================
  // Controller states
  typedef enum logic [3:0] {
    JbsTlr, JbsRti, JbsSelDr, JbsCapDr, JbsShDr, JbsEx1Dr, JbsPauDr, JbsEx2Dr,
    JbsUpdDr, JbsSelIr, JbsCapIr, JbsShIr, JbsEx1Ir, JbsPauIr, JbsEx2Ir, JbsUpdIr
  } jbs_state_t;
endpackage

// ===== logic/jbsisp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Two-flop synchroniser for pin inputs
module jbsisp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk, // System clock
  input  wire logic         rst,     // Async reset
  input  wire logic [W-1:0] din,     // Async input
  output logic      [W-1:0] dout     // Synchronised
);
  logic [W-1:0] meta_q; // First stage, read only by second
  // Both stages registered, reset to zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // jbsisp_sync
`default_nettype wire

// ===== tb/jbsisp_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checker: pin safety, user I/O release, reset state
module jbsisp_port_properties #(
  parameter int NumIo    = 24, // User I/O pins
  parameter int ChainLen = 96  // Boundary cells
) (
  input wire logic             sys_clk,     // System clock
  input wire logic             rst,         // Async reset
  input wire logic             testPortEn,  // Port in use
  input wire logic             tdoOe,       // Data out enable
  input wire logic [3:0]       portUserOut, // Core drive for port pins
  input wire logic [3:0]       portUserOe,  // Core enable for port pins
  input wire logic [3:0]       portPinOut,  // Port pin drive
  input wire logic [3:0]       portPinOe,   // Port pin enable
  input wire logic [NumIo-1:0] pinIn,       // Pin levels
  input wire logic [NumIo-1:0] coreIn,      // Levels to core
  input wire logic [NumIo-1:0] pinOe,       // Pin enables
  input wire logic             pullUpEn,    // Weak pull-ups
  input wire logic             progBusy,    // Programming active
  input wire logic             doneFlag     // Completion flag
);
  // ==========================================================
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_prog_pins_off: assert property (progBusy |-> pinOe == '0)
    else $error("Pin driven while programming");
  a_pull_with_prog: assert property (pullUpEn == progBusy)
    else $error("Pull-ups do not follow programming mode");
  a_drive_needs_done: assert property (|pinOe |-> doneFlag && !progBusy)
    else $error("Pin driven before completion flag set");
  a_done_set_prog: assert property ($rose(doneFlag) |-> progBusy)
    else $error("Completion flag set outside programming");
  a_done_idle_hold: assert property (!progBusy ##1 !progBusy |-> $stable(doneFlag))
    else $error("Completion flag moved outside programming");
  a_core_sees_pins: assert property (coreIn == pinIn)
    else $error("Core input does not follow pin");
  a_user_io_pass: assert property (!testPortEn |->
    portPinOut == portUserOut && portPinOe == portUserOe && !tdoOe)
    else $error("Port pins not released to user logic");
  a_port_pins_held: assert property (testPortEn |-> portPinOe == 4'h0)
    else $error("Port pins driven by user logic while port in use");
  a_reset_safe: assert property ($fell(rst) |-> !doneFlag && !progBusy && pinOe == '0)
    else $error("Unsafe state after reset");

  c_prog_exit: cover property (progBusy ##1 !progBusy && doneFlag);
  c_user_io: cover property (!testPortEn);
  c_pins_drive: cover property (|pinOe);
endmodule // jbsisp_port_properties

bind jbsisp_port jbsisp_port_properties #(.NumIo(NumIo), .ChainLen(ChainLen))
  i_jbsisp_port_properties (.sys_clk(sys_clk), .rst(rst), .testPortEn(testPortEn),
  .tdoOe(tdoOe), .portUserOut(portUserOut), .portUserOe(portUserOe),
  .portPinOut(portPinOut), .portPinOe(portPinOe), .pinIn(pinIn), .coreIn(coreIn),
  .pinOe(pinOe), .pullUpEn(pullUpEn), .progBusy(progBusy), .doneFlag(doneFlag));
`default_nettype wire

// ===== tb/jbsisp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Test controller model; TCK only runs inside a frame
module jbsisp_ctrl_model (
  input  wire logic sys_clk, // System clock
  output logic      tck,     // Test clock, 80 ns
  output logic      tms,     // Mode select
  output logic      tdi,     // Serial data out
  input  wire logic tdo      // Serial data in
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 80 ns TCK period, four clocks low and four high
  // TDO is read just before the rise, as it settles after the fall
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge sys_clk);
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge sys_clk);
    o = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b0;
  endtask
  // Five ones reach reset from any state, then idle
  task automatic to_idle();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int len, input logic [127:0] d,
                      output logic [127:0] q);
    logic o;
    q = '0;
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < len; i++) begin
      tick(i == len - 1, d[i], o);
      q[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o); // Extra idle rise arms programming actions
  endtask
endmodule // jbsisp_ctrl_model
`default_nettype wire

// ===== tb/jbsisp_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench top
module jbsisp_port_bench;
  localparam int NumIo = 24;
  localparam int ChainLen = 96;
  localparam logic [31:0] ExpId = {jbsisp_pkg::IdVersion, jbsisp_pkg::IdPart,
                                   jbsisp_pkg::IdMaker, jbsisp_pkg::IdLsb};
  logic             sys_clk, rst, testPortEn, tckPin, tmsPin, tdiPin, tdoOut, tdoOe;
  logic [3:0]       portUserOut, portUserOe, portPinOut, portPinOe;
  logic [NumIo-1:0] coreOut, coreOe, pinIn, coreIn, pinOut, pinOe;
  logic             pullUpEn, progBusy, doneFlag;
  logic [127:0]     q;         // Last scan result
  int               error_cnt; // Mismatches
  int               tests_run; // Comparisons
  jbsisp_port #(.NumIo(NumIo), .ChainLen(ChainLen)) i_jbsisp_port (
    .sys_clk(sys_clk), .rst(rst), .testPortEn(testPortEn), .tckPin(tckPin),
    .tmsPin(tmsPin), .tdiPin(tdiPin), .tdoOut(tdoOut), .tdoOe(tdoOe),
    .portUserOut(portUserOut), .portUserOe(portUserOe), .portPinOut(portPinOut),
    .portPinOe(portPinOe), .coreOut(coreOut), .coreOe(coreOe), .pinIn(pinIn),
    .coreIn(coreIn), .pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn),
    .progBusy(progBusy), .doneFlag(doneFlag));
  jbsisp_ctrl_model i_jbsisp_ctrl_model (.sys_clk(sys_clk), .tck(tckPin), .tms(tmsPin),
    .tdi(tdiPin), .tdo(tdoOut));
  always #5 sys_clk = ~sys_clk;
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic load(input logic [9:0] code);
    i_jbsisp_ctrl_model.scan(1'b1, 10, {118'h0, code}, q);
  endtask
  // Pin-level cells sit at every third chain position
  function automatic logic [127:0] in_cells(input logic [NumIo-1:0] v);
    logic [127:0] r;
    r = '0;
    for (int k = 0; k < NumIo; k++) r[3*k] = v[k];
    return r;
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_idcode();
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(q[31:0], ExpId, "id word");
    chk(q[0], 1'b1, "id lsb");
    load(jbsisp_pkg::InsBypass);
    chk(q[9:0], jbsisp_pkg::IrCaptureVal, "ir capture");
    $display("idcode test done");
  endtask
  task automatic t_bypass();
    // Unknown code must fall back to the one-stage path
    logic [9:0] codes [2];
    codes = '{jbsisp_pkg::InsBypass, 10'h155};
    foreach (codes[i]) begin
      load(codes[i]);
      i_jbsisp_ctrl_model.scan(1'b0, 8, 128'hB4, q);
      chk(q[7:0], 8'h68, "bypass delay");
    end
    $display("bypass test done");
  endtask
  task automatic t_sample();
    load(jbsisp_pkg::InsSample);
    i_jbsisp_ctrl_model.scan(1'b0, ChainLen, '0, q);
    chk(q & in_cells('1), in_cells(pinIn), "sample capture");
    chk(pinOe, '0, "sample pins idle");
    $display("sample test done");
  endtask
  task automatic t_program();
    logic [31:0] w;
    w = 32'h13579BDF;
    load(jbsisp_pkg::InsUsercode);
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(q[31:0], jbsisp_pkg::UserCodeDefault, "user code default");
    load(jbsisp_pkg::InsSetDone);
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(doneFlag, 1'b0, "done refused");
    load(jbsisp_pkg::InsEnable);
    chk({progBusy, pullUpEn}, 2'h3, "prog mode");
    chk(pinOe, '0, "prog pins off");
    load(jbsisp_pkg::InsProgram);
    i_jbsisp_ctrl_model.scan(1'b0, 32, {96'h0, w}, q);
    load(jbsisp_pkg::InsVerify);
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(q[15:0], w[15:0] & jbsisp_pkg::CfgErased, "verify");
    chk(pinOe, '0, "pins off before flag");
    load(jbsisp_pkg::InsSetDone);
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(doneFlag, 1'b1, "done set last");
    load(jbsisp_pkg::InsDisable);
    chk({progBusy, pinOe}, {1'b0, coreOe}, "pins released");
    chk(pinOut, coreOut, "core drive");
    load(jbsisp_pkg::InsUsercode);
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(q[31:0], w, "user code");
    $display("program test done");
  endtask
  task automatic t_extest();
    logic [127:0] d;
    d = '0;
    for (int k = 0; k < NumIo; k++) d[3*k+2 -: 2] = {1'b1, k[0]};
    load(jbsisp_pkg::InsExtest);
    i_jbsisp_ctrl_model.scan(1'b0, ChainLen, d, q);
    chk(q & in_cells('1), in_cells(pinIn), "extest capture");
    chk({pinOe, pinOut}, {24'hFFFFFF, 24'hAAAAAA}, "extest drive");
    load(jbsisp_pkg::InsEnable);
    load(jbsisp_pkg::InsErase);
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(doneFlag, 1'b0, "erase clears flag");
    load(jbsisp_pkg::InsDisable);
    chk(pinOe, '0, "erased pins off");
    $display("extest test done");
  endtask
  task automatic t_port_unused();
    @(posedge sys_clk);
    testPortEn <= 1'b0;
    portUserOut <= 4'hA;
    portUserOe <= 4'h6;
    repeat (3) @(posedge sys_clk);
    chk({portPinOut, portPinOe, tdoOe}, {4'hA, 4'h6, 1'b0}, "user io");
    testPortEn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(portPinOe, 4'h0, "port reclaimed");
    i_jbsisp_ctrl_model.to_idle();
    i_jbsisp_ctrl_model.scan(1'b0, 32, '0, q);
    chk(q[31:0], ExpId, "id after hold");
    $display("port release test done");
  endtask
  // ==========================================================
  // Verdict
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog; every wait above is a fixed count, this catches a stuck run
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    testPortEn = 1'b1;
    portUserOut = 4'h0;
    portUserOe = 4'h0;
    coreOut = 24'hCC33AA;
    coreOe = 24'hF0F0F0;
    pinIn = 24'h5A3C96;
    error_cnt = 0;
    tests_run = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    i_jbsisp_ctrl_model.to_idle();
    t_idcode();
    t_bypass();
    t_sample();
    t_program();
    t_extest();
    t_port_unused();
    test_done();
  end
endmodule // jbsisp_port_bench
`default_nettype wire
